// *** emb_pkg.sv ***
/*
  shared constants and types of the external memory bus strobe block.
  assumes one 100 MHz processor clock and no software-visible registers.
*/
package emb_pkg;

  localparam int unsigned EMB_ADDR_W = 16; // external address bus width
  localparam int unsigned EMB_DATA_W = 16; // external data bus width
  localparam int unsigned EMB_WS_W   = 3;  // wait-state count field width

  localparam logic [EMB_WS_W-1:0]   EMB_WS_ZERO   = 3'h0;
  localparam logic [EMB_ADDR_W-1:0] EMB_ADDR_RST  = 16'h0000;
  localparam logic [EMB_DATA_W-1:0] EMB_DATA_RST  = 16'h0000;

  // external space selected by an access
  typedef enum logic [1:0] {
    EMB_SP_PROG = 2'b00,
    EMB_SP_DATA = 2'b01,
    EMB_SP_IO   = 2'b10
  } emb_space_t;

  // bus cycle sequencer
  typedef enum logic [1:0] {
    EMB_ST_IDLE   = 2'b00,
    EMB_ST_ACCESS = 2'b01,
    EMB_ST_END    = 2'b10
  } emb_state_t;

endpackage : emb_pkg

// *** emb_wait_if.sv ***
/*
  carrier between the bus sequencer and its wait-state timer.
  assumes both ends run on the same processor clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface emb_wait_if;
  import emb_pkg::*;

  logic                start;    // one-cycle pulse: access begins
  logic [EMB_WS_W-1:0] ws;       // configured software wait states
  logic                ready_s;  // synchronised ready pin
  logic                done;     // one-cycle pulse: access may complete

  modport seq   (output start, output ws, output ready_s, input done);
  modport timer (input start, input ws, input ready_s, output done);
endinterface : emb_wait_if

`default_nettype wire

// *** emb_wait.sv ***
/*
  wait-state timer: counts software wait states, then polls ready.
  assumes ready_s is already synchronised to sys_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module emb_wait (
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  emb_wait_if.timer wif
);
  import emb_pkg::*;

  typedef struct packed {
    logic                busy;
    logic [EMB_WS_W-1:0] cnt;
    logic                done;
  } emb_wait_st_t;

  emb_wait_st_t st;
  emb_wait_st_t next_st;

  // count down wait states, then poll ready
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (wif.start) begin
      next_st.busy = 1'b1;
      next_st.cnt  = wif.ws;
    end else if (st.busy) begin
      if (st.cnt != EMB_WS_ZERO) begin
        next_st.cnt = st.cnt - 3'h1;
      end else if (wif.ws == EMB_WS_ZERO) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      // low ready costs one more cycle
      end else if (wif.ready_s) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wif.done = st.done;

endmodule : emb_wait

`default_nettype wire

// *** emb_bus_ctrl.sv ***
/*
  external memory and i/o bus master: space, access, read and write
  strobes, direction qualifiers, address and write data drive.
  assumes a processor-side request port on sys_clk_i; pin inputs are
  asynchronous and pass two flip-flops; pads resolve level from enables.
*/
// Contract
// - space strobes idle high and go low only for an access to their space.
// - space strobes float in reset, in power down and while output disable is low.
// - the read/write qualifier idles high and goes low only for a write.
// - the read/write qualifier floats in power down and while output disable is low.
// - the write/read qualifier is the inverse of read/write, high only on writes.
// - the read strobe goes low for every external read in any space.
// - the read strobe floats while output disable is low.
// - write data drive starts on the same edge as the write strobe falls.
// - the write strobe goes low on every external write and floats on output disable.
// - the access strobe goes low for each off-chip cycle and is high otherwise.
// - the access strobe floats in power down and while output disable is low.
// - ready sampled low makes the bus wait a cycle and sample again.
// - ready is only looked at when at least one wait state is configured.
// - with the external interface disabled every access flags an illegal address.
// - the address bus is 16 bits, one pin per bit.
`timescale 1ns/1ps
`default_nettype none

module emb_bus_ctrl (
  input  wire logic                                sys_clk_i,
  input  wire logic                                nrst_i,
  // processor request side
  input  wire logic                                acc_req_i,
  input  wire emb_pkg::emb_space_t                 acc_space_i,
  input  wire logic                                acc_write_i,
  input  wire logic [emb_pkg::EMB_ADDR_W-1:0]      acc_addr_i,
  input  wire logic [emb_pkg::EMB_DATA_W-1:0]      acc_wdata_i,
  input  wire logic [emb_pkg::EMB_WS_W-1:0]        wait_state_config_i,
  input  wire logic                                ext_if_enable_i,
  input  wire logic                                power_down_i,
  output logic                                     acc_done_o,
  output logic                                     illegal_addr_o,
  output logic [emb_pkg::EMB_DATA_W-1:0]           acc_rdata_o,
  // pins
  input  wire logic                                output_disable_n_i,
  input  wire logic                                ready_i,
  input  wire logic [emb_pkg::EMB_DATA_W-1:0]      data_i,
  output logic [emb_pkg::EMB_DATA_W-1:0]           data_o,
  output logic                                     data_oe_o,
  output logic [emb_pkg::EMB_ADDR_W-1:0]           addr_o,
  output logic                                     addr_oe_o,
  output logic                                     data_space_strobe_n_o,
  output logic                                     io_space_strobe_n_o,
  output logic                                     program_space_strobe_n_o,
  output logic                                     space_oe_o,
  output logic                                     ext_access_strobe_n_o,
  output logic                                     ext_access_oe_o,
  output logic                                     rw_o,
  output logic                                     rw_oe_o,
  output logic                                     wr_qual_o,
  output logic                                     wr_qual_oe_o,
  output logic                                     rd_n_o,
  output logic                                     rd_oe_o,
  output logic                                     we_n_o,
  output logic                                     we_oe_o
);
  import emb_pkg::*;

  typedef struct packed {
    emb_state_t            state;
    logic [1:0]            off_sync;   // output-disable synchroniser
    logic [1:0]            rdy_sync;   // ready synchroniser
    logic [EMB_DATA_W-1:0] din_s1;
    logic [EMB_DATA_W-1:0] din_s2;
    logic                  start;
    logic                  done;
    logic                  illegal;
    logic [EMB_DATA_W-1:0] rdata;
    logic [EMB_DATA_W-1:0] wdata;
    logic                  data_oe;
    logic [EMB_ADDR_W-1:0] addr;
    logic                  addr_oe;
    logic                  ds_n;
    logic                  is_n;
    logic                  ps_n;
    logic                  space_oe;
    logic                  ext_access_strobe_n_n;
    logic                  ext_access_strobe_n_oe;
    logic                  rw;
    logic                  rw_oe;
    logic                  wrq;
    logic                  wrq_oe;
    logic                  rd_n;
    logic                  rd_oe;
    logic                  we_n;
    logic                  we_oe;
  } emb_ctrl_st_t;

  emb_ctrl_st_t st;
  emb_ctrl_st_t next_st;
  logic         off;        // output disable asserted (synchronised)

  emb_wait_if wif ();

  emb_wait u_wait (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .wif       (wif)
  );

  assign wif.start   = st.start;
  assign wif.ws      = wait_state_config_i;
  assign wif.ready_s = st.rdy_sync[1];
  assign off         = !st.off_sync[1];

  // sequencer, pin levels and pin enables
  always_comb begin
    next_st             = st;
    next_st.off_sync    = {st.off_sync[0], output_disable_n_i};
    next_st.rdy_sync    = {st.rdy_sync[0], ready_i};
    next_st.din_s1      = data_i;
    next_st.din_s2      = st.din_s1;
    next_st.start       = 1'b0;
    next_st.done        = 1'b0;
    next_st.illegal     = 1'b0;
    case (st.state)
      EMB_ST_IDLE: begin
        if (acc_req_i) begin
          if (!ext_if_enable_i || acc_space_i == 2'b11) begin
            next_st.illegal = 1'b1;
            next_st.done    = 1'b1;
          end else begin
            next_st.state   = EMB_ST_ACCESS;
            next_st.start   = 1'b1;
            next_st.addr    = acc_addr_i;
            next_st.wdata   = acc_wdata_i;
            next_st.ps_n    = (acc_space_i != EMB_SP_PROG);
            next_st.ds_n    = (acc_space_i != EMB_SP_DATA);
            next_st.is_n    = (acc_space_i != EMB_SP_IO);
            next_st.ext_access_strobe_n_n  = 1'b0;
            next_st.rw      = !acc_write_i;
            next_st.wrq     = acc_write_i;
            next_st.rd_n    = acc_write_i;
            next_st.we_n    = !acc_write_i;
          end
        end
      end
      EMB_ST_ACCESS: begin
        if (wif.done) begin
          next_st.state  = EMB_ST_END;
          next_st.rdata  = st.rw ? st.din_s2 : st.rdata;
          next_st.done   = 1'b1;
          next_st.ps_n   = 1'b1;
          next_st.ds_n   = 1'b1;
          next_st.is_n   = 1'b1;
          next_st.ext_access_strobe_n_n = 1'b1;
          next_st.rw     = 1'b1;
          next_st.wrq    = 1'b0;
          next_st.rd_n   = 1'b1;
          next_st.we_n   = 1'b1;
        end
      end
      EMB_ST_END: begin
        next_st.state = EMB_ST_IDLE;
      end
      default: begin
        next_st.state = EMB_ST_IDLE;
      end
    endcase
    // data drive starts with write strobe
    next_st.data_oe  = !next_st.we_n && !off;
    next_st.addr_oe  = !off;
    next_st.space_oe = !off && !power_down_i;
    next_st.ext_access_strobe_n_oe  = !off && !power_down_i;
    next_st.rw_oe    = !off && !power_down_i;
    next_st.wrq_oe   = !off;
    next_st.rd_oe    = !off;
    next_st.we_oe    = !off;
  end

  // state register; space strobes float in reset
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st          <= '0;
      st.state    <= EMB_ST_IDLE;
      st.off_sync <= 2'h3;
      st.rdy_sync <= 2'h3;
      st.addr     <= EMB_ADDR_RST;
      st.wdata    <= EMB_DATA_RST;
      st.ds_n     <= 1'b1;
      st.is_n     <= 1'b1;
      st.ps_n     <= 1'b1;
      st.ext_access_strobe_n_n   <= 1'b1;
      st.ext_access_strobe_n_oe  <= 1'b1;
      st.rw       <= 1'b1;
      st.rw_oe    <= 1'b1;
      st.wrq_oe   <= 1'b1;
      st.rd_n     <= 1'b1;
      st.rd_oe    <= 1'b1;
      st.we_n     <= 1'b1;
      st.we_oe    <= 1'b1;
      st.addr_oe  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign acc_done_o               = st.done;
  assign illegal_addr_o           = st.illegal;
  assign acc_rdata_o              = st.rdata;
  assign data_o                   = st.wdata;
  assign data_oe_o                = st.data_oe;
  assign addr_o                   = st.addr;
  assign addr_oe_o                = st.addr_oe;
  assign data_space_strobe_n_o    = st.ds_n;
  assign io_space_strobe_n_o      = st.is_n;
  assign program_space_strobe_n_o = st.ps_n;
  assign space_oe_o               = st.space_oe;
  assign ext_access_strobe_n_o    = st.ext_access_strobe_n_n;
  assign ext_access_oe_o          = st.ext_access_strobe_n_oe;
  assign rw_o                     = st.rw;
  assign rw_oe_o                  = st.rw_oe;
  assign wr_qual_o                = st.wrq;
  assign wr_qual_oe_o             = st.wrq_oe;
  assign rd_n_o                   = st.rd_n;
  assign rd_oe_o                  = st.rd_oe;
  assign we_n_o                   = st.we_n;
  assign we_oe_o                  = st.we_oe;

endmodule : emb_bus_ctrl

`default_nettype wire

// *** emb_bus_ctrl_properties.sv ***
/*
  checker for the bus strobe block, bound to emb_bus_ctrl.
  assumes it sees only the top ports, on one clock with active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module emb_bus_ctrl_properties (
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  input wire logic [2:0]  wait_state_config_i,
  input wire logic        power_down_i,
  input wire logic        output_disable_n_i,
  input wire logic        acc_done_o,
  input wire logic [15:0] addr_o,
  input wire logic        data_space_strobe_n_o,
  input wire logic        io_space_strobe_n_o,
  input wire logic        program_space_strobe_n_o,
  input wire logic        space_oe_o,
  input wire logic        ext_access_strobe_n_o,
  input wire logic        ext_access_oe_o,
  input wire logic        rw_o,
  input wire logic        rw_oe_o,
  input wire logic        wr_qual_o,
  input wire logic        rd_n_o,
  input wire logic        rd_oe_o,
  input wire logic        we_n_o,
  input wire logic        we_oe_o,
  input wire logic        data_oe_o
);
  // the three space strobes as one group
  wire [2:0] sp = {data_space_strobe_n_o, io_space_strobe_n_o, program_space_strobe_n_o};

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  a_space_one_low: assert property (!(&sp) |-> $onehot0(~sp) && !ext_access_strobe_n_o)
    else $error("space strobe low outside a single access");
  a_qual_inverse: assert property (wr_qual_o == !rw_o)
    else $error("write qualifier not inverse of rw");
  a_write_marks: assert property (!rw_o |-> !ext_access_strobe_n_o && !rd_n_o == 1'b0)
    else $error("rw low outside a write cycle");
  a_we_in_cycle: assert property (!we_n_o |-> !rw_o && !ext_access_strobe_n_o)
    else $error("write strobe low outside a write cycle");
  a_rd_in_cycle: assert property (!rd_n_o |-> rw_o && !ext_access_strobe_n_o)
    else $error("read strobe low outside a read cycle");
  a_drive_on_we: assert property ($fell(we_n_o) && we_oe_o |-> data_oe_o)
    else $error("data not driven as write strobe falls");
  a_off_floats: assert property (!output_disable_n_i [*4] |->
    !(space_oe_o | rw_oe_o | rd_oe_o | we_oe_o | ext_access_oe_o | data_oe_o))
    else $error("outputs driven while output disable low");
  a_pd_floats: assert property (power_down_i [*2] |->
    !(space_oe_o | rw_oe_o | ext_access_oe_o))
    else $error("strobes driven in power down");
  a_hold_in_wait: assert property (
    !ext_access_strobe_n_o && $past(!ext_access_strobe_n_o)
    |-> $stable(addr_o) && $stable(rw_o) && $stable(sp))
    else $error("bus changed during an access");
  a_zero_ws_time: assert property (
    $fell(ext_access_strobe_n_o) && wait_state_config_i == 3'h0 |-> ##3 acc_done_o)
    else $error("zero wait access not done in time");
endmodule : emb_bus_ctrl_properties

bind emb_bus_ctrl emb_bus_ctrl_properties u_props (.sys_clk_i, .nrst_i, .wait_state_config_i,
  .power_down_i, .output_disable_n_i, .acc_done_o, .addr_o, .data_space_strobe_n_o,
  .io_space_strobe_n_o, .program_space_strobe_n_o, .space_oe_o, .ext_access_strobe_n_o,
  .ext_access_oe_o, .rw_o, .rw_oe_o, .wr_qual_o, .rd_n_o, .rd_oe_o, .we_n_o, .we_oe_o,
  .data_oe_o);

`default_nettype wire

// *** emb_ext_mem.sv ***
/*
  external memory model, 16 words, shared by all three spaces.
  assumes the bench merges its read data with the controller's write drive.
*/
`timescale 1ns/1ps
`default_nettype none

module emb_ext_mem (
  input  wire logic        sys_clk_i,
  input  wire logic        rd_n_i,
  input  wire logic        we_n_i,
  input  wire logic        ext_access_strobe_n_n_i,
  input  wire logic        wr_en_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [3:0]  stall_i,
  output logic      [15:0] rdata_o,
  output logic             ready_o
);
  logic [15:0] mem [16];
  logic [15:0] last;
  logic [3:0]  cnt;

  // stall count, write capture, last value read
  always @(posedge sys_clk_i) begin
    if (ext_access_strobe_n_n_i) cnt <= stall_i;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    if (!we_n_i && wr_en_i) mem[addr_i[3:0]] <= wdata_i;
    if (!rd_n_i) last <= mem[addr_i[3:0]];
  end
  assign ready_o = ext_access_strobe_n_n_i || cnt == 4'h0; // pulled up when idle
  // released bus shows the inverse, not stale data
  assign rdata_o = rd_n_i ? ~last : mem[addr_i[3:0]];
endmodule : emb_ext_mem

`default_nettype wire

// *** tb_external_memory_bus_strobes.sv ***
/*
  bench: random and corner accesses through the bus strobe block.
  assumes emb_pkg, the checker and the memory model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_external_memory_bus_strobes;
  import emb_pkg::*;
  logic        sys_clk_i, nrst_i, acc_req_i, acc_write_i, ext_if_enable_i, power_down_i;
  logic        output_disable_n_i, ready_i, acc_done_o, illegal_addr_o, data_oe_o, addr_oe_o;
  logic        data_space_strobe_n_o, io_space_strobe_n_o, program_space_strobe_n_o;
  logic        space_oe_o, ext_access_strobe_n_o, ext_access_oe_o, rw_o, rw_oe_o, wr_qual_o;
  logic        wr_qual_oe_o, rd_n_o, rd_oe_o, we_n_o, we_oe_o;
  logic [15:0] acc_addr_i, acc_wdata_i, acc_rdata_o, data_i, data_o, addr_o, mem_d;
  logic [15:0] shadow [16];
  logic [2:0]  wait_state_config_i;
  logic [3:0]  stall;
  emb_space_t  acc_space_i;
  int          n_errors, checks_done, seed, cyc;

  emb_bus_ctrl DUT (.sys_clk_i, .nrst_i, .acc_req_i, .acc_space_i, .acc_write_i, .acc_addr_i,
    .acc_wdata_i, .wait_state_config_i, .ext_if_enable_i, .power_down_i, .acc_done_o,
    .illegal_addr_o, .acc_rdata_o, .output_disable_n_i, .ready_i, .data_i, .data_o, .data_oe_o,
    .addr_o, .addr_oe_o, .data_space_strobe_n_o, .io_space_strobe_n_o,
    .program_space_strobe_n_o, .space_oe_o, .ext_access_strobe_n_o, .ext_access_oe_o, .rw_o,
    .rw_oe_o, .wr_qual_o, .wr_qual_oe_o, .rd_n_o, .rd_oe_o, .we_n_o, .we_oe_o);
  emb_ext_mem u_mem (.sys_clk_i, .rd_n_i(rd_n_o), .we_n_i(we_n_o),
    .ext_access_strobe_n_n_i(ext_access_strobe_n_o), .wr_en_i(data_oe_o), .addr_i(addr_o), .wdata_i(data_o),
    .stall_i(stall), .rdata_o(mem_d), .ready_o(ready_i));
  // controller write drive wins over the memory
  assign data_i = data_oe_o ? data_o : mem_d;

  // clock and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      results();
    end
  end

  task automatic results;
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // pins in the first access cycle: ds is ps rd_n we_n rw wr_qual
  function automatic logic [6:0] exp_pins(input emb_space_t sp, input logic wr, input logic ill);
    if (ill) return 7'h7e;
    return {sp != EMB_SP_DATA, sp != EMB_SP_IO, sp != EMB_SP_PROG, wr, !wr, !wr, wr};
  endfunction : exp_pins

  // cycles from raising the request to seeing done
  function automatic int exp_lat(input logic [2:0] ws, input logic [3:0] st, input logic ill);
    // illegal: done on the edge that takes the request; legal: four cycles plus waits,
    // ready counts two cycles late through the pin synchroniser
    if (ill) return 1;
    if (ws == 3'h0) return 4;
    if (st + 1 <= ws) return ws + 4;
    return st + 5;
  endfunction : exp_lat

  task automatic access(input emb_space_t sp, input logic wr, input logic [15:0] a, d);
    logic [6:0] pins;
    logic       ill;
    int         n;
    @(posedge sys_clk_i);
    #1;
    ill = !ext_if_enable_i || sp == 2'b11;
    acc_space_i = sp;
    acc_write_i = wr;
    acc_addr_i = a;
    acc_wdata_i = d;
    acc_req_i = 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      n++;
      if (n == 1 && ill) acc_req_i = 1'b0;
      if (n == 1) pins = {data_space_strobe_n_o, io_space_strobe_n_o,
                          program_space_strobe_n_o, rd_n_o, we_n_o, rw_o, wr_qual_o};
      if (n == 2 && !ill) check(addr_o, a);
    end while (acc_done_o !== 1'b1 && n < 40);
    acc_req_i = 1'b0;
    check(16'(pins), 16'(exp_pins(sp, wr, ill)));
    check(16'(illegal_addr_o), 16'(ill));
    check(16'(n), 16'(exp_lat(wait_state_config_i, stall, ill)));
    if (wr && !ill) shadow[a[3:0]] = d;
    if (!wr && !ill) check(acc_rdata_o, shadow[a[3:0]]);
  endtask : access

  initial begin
    seed = 32'hb940;
    {n_errors, checks_done, cyc} = '0;
    {nrst_i, acc_req_i, acc_write_i, power_down_i, acc_addr_i, acc_wdata_i} = '0;
    {ext_if_enable_i, output_disable_n_i} = 2'b11;
    acc_space_i = EMB_SP_PROG;
    wait_state_config_i = 3'h0;
    stall = 4'h0;
    repeat (8) @(posedge sys_clk_i);
    #1;
    check(16'({space_oe_o, ext_access_strobe_n_o, rw_o, wr_qual_o, rd_n_o, we_n_o}), 16'h001b);
    nrst_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    check(16'({space_oe_o, ext_access_oe_o, rw_oe_o, rd_oe_o, we_oe_o, addr_oe_o}), 16'h003f);
    for (int i = 0; i < 48; i++) begin
      wait_state_config_i = 3'($random(seed));
      stall = 4'($random(seed) & 7);
      access(emb_space_t'(i % 3), i < 16 || $random(seed) & 1, {12'($random(seed)), 4'(i)},
             16'($random(seed)));
    end
    // corners: ready ignored at zero waits, long count, short count under long stall
    for (int j = 0; j < 3; j++) begin
      wait_state_config_i = 3'(j == 1 ? 7 : j);
      stall = 4'h7;
      access(EMB_SP_IO, 1'b0, 16'(j), 16'h0);
    end
    ext_if_enable_i = 1'b0;
    for (int k = 0; k < 4; k++) access(emb_space_t'(k), 1'(k), 16'h0001, 16'h0);
    ext_if_enable_i = 1'b1;
    access(emb_space_t'(2'b11), 1'b0, 16'h0002, 16'h0);
    output_disable_n_i = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    check(16'({space_oe_o, ext_access_oe_o, rw_oe_o, wr_qual_oe_o, rd_oe_o, we_oe_o, addr_oe_o}), 16'h0000);
    output_disable_n_i = 1'b1;
    power_down_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    check(16'({space_oe_o, ext_access_oe_o, rw_oe_o, wr_qual_oe_o, rd_oe_o, we_oe_o}), 16'h0007);
    power_down_i = 1'b0;
    nrst_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    check(16'({space_oe_o, ext_access_strobe_n_o, rw_o, wr_qual_o, rd_n_o, we_n_o}), 16'h001b);
    nrst_i = 1'b1;
    access(EMB_SP_DATA, 1'b0, 16'h0003, 16'h0);
    results();
  end
endmodule : tb_external_memory_bus_strobes

`default_nettype wire
